// [design/swc_regs.vh]
// Purpose: constants of the sleep/wake controller
// Assumes: 200 MHz system clock, 8-bit registers
// Notes:   offsets are word indices on the plain register port
`ifndef SWC_REGS_VH
`define SWC_REGS_VH

`define SWC_ADDR_W          3
`define SWC_OFF_INTCTL      3'h0
`define SWC_OFF_PFLAGS      3'h1
`define SWC_OFF_WDTCTL      3'h2
`define SWC_OFF_PIRQEN      3'h3

// interrupt_control_reg fields
`define SWC_IC_GLB_EN       7
`define SWC_IC_PER_EN       6
`define SWC_IC_TMR_EN       5
`define SWC_IC_PIN_EN       4
`define SWC_IC_CHG_EN       3
`define SWC_IC_TMR_FLG      2
`define SWC_IC_PIN_FLG      1
`define SWC_IC_CHG_FLG      0
`define SWC_IC_RST          8'h00

// processor_flags_reg fields (both flags active low)
`define SWC_PF_EXPIRED      4
`define SWC_PF_PDOWN        3
`define SWC_PF_RST          8'h18
`define SWC_PF_SW_MASK      8'h07

// watchdog_control_reg fields
`define SWC_WC_PS_HI        5
`define SWC_WC_PS_LO        1
`define SWC_WC_SWEN         0
`define SWC_WC_RST          8'h16
`define SWC_WC_MASK         8'h3f
`define SWC_PS_MAX          5'h12
`define SWC_PS_BASE_LOG2    5

`define SWC_PIRQEN_RST      8'h00

// watchdog modes
`define SWC_WM_OFF          2'h0
`define SWC_WM_SW           2'h1
`define SWC_WM_NOSLEEP      2'h2
`define SWC_WM_ON           2'h3

// timing
`define SWC_CLK_MHZ         200
`define SWC_LF_KHZ          31
`define SWC_OST_PERIODS     1024
`define SWC_ISR_VECTOR      13'h0004
`define SWC_PC_W            13

`endif

// [design/swc_sync.v]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk_i
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module swc_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         nrst_i,
    // data
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    genvar g;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    generate
        for (g = 0; g < W; g = g + 1) begin : bit_g
            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    q_o[g] <= 1'b0;
                end else if (s2_reg[g] == s3_reg[g]) begin
                    q_o[g] <= s3_reg[g];
                end
            end
        end
    endgenerate
endmodule

// [design/swc_top.v]
// Purpose: sleep entry, wake-up and watchdog control
// Assumes: cpu drives instruction strobes on clk_i; pins are asynchronous
// Notes:   the 1024-period start-up wait counts clk_i periods
`timescale 1ns/1ps
`include "swc_regs.vh"
module swc_top #(
    parameter NPI        = 8,
    parameter OST_CYCLES = `SWC_OST_PERIODS
) (
    // clock and reset
    input  wire                    clk_i,
    input  wire                    nrst_i,
    // register port
    input  wire [`SWC_ADDR_W-1:0]  addr_i,
    input  wire [7:0]              wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [7:0]              rdata_o,
    // cpu instruction strobes
    input  wire                    sleep_instr_i,
    input  wire                    watchdog_kick_instr_i,
    input  wire [`SWC_PC_W-1:0]    pc_i,
    // interrupt sources
    input  wire                    tmr0_evt_i,
    input  wire                    ioc_evt_i,
    input  wire [NPI-1:0]          periph_irq_i,
    // pins and straps
    input  wire                    ext_irq_pin_i,
    input  wire                    external_reset_pin_n_i,
    input  wire                    brownout_i,
    input  wire                    low_freq_internal_osc_i,
    input  wire [1:0]              wdt_mode_i,
    input  wire                    ext_reset_en_i,
    input  wire                    brownout_en_i,
    input  wire                    xtal_mode_i,
    input  wire                    two_speed_i,
    // clock and pin control
    output reg                     cpu_clk_en_o,
    output reg                     lf_clk_en_o,
    output reg                     timer_osc_en_o,
    output reg                     adc_dedicated_rc_clock_en_o,
    output reg                     cap_osc_en_o,
    output reg                     io_hold_o,
    // cpu control
    output reg                     sys_reset_o,
    output reg                     resume_o,
    output reg                     isr_call_o,
    output reg  [`SWC_PC_W-1:0]    isr_vector_o,
    output reg  [`SWC_PC_W-1:0]    prefetch_addr_o,
    output reg                     prefetch_o,
    output reg                     asleep_o
);
    localparam ST_AWAKE = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_OST   = 2'h2;
    localparam CNT_W    = 16;
    localparam [CNT_W-1:0] OST_LAST = OST_CYCLES[CNT_W-1:0] - 16'h0001;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire [3:0] pin_s;
    // reset request inverted first so the filter's reset level is its idle level
    swc_sync #(
        .W      (4)
    ) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({low_freq_internal_osc_i, brownout_i, ~external_reset_pin_n_i,
                  ext_irq_pin_i}),
        .q_o    (pin_s)
    );
    wire lf_s      = pin_s[3];
    wire bor_s     = pin_s[2];
    wire pin_rst_s = pin_s[1];
    wire extirq_s  = pin_s[0];

    reg lf_d_reg;
    reg extirq_d_reg;
    wire lf_tick   = lf_s & ~lf_d_reg;
    wire ext_edge  = extirq_s & ~extirq_d_reg;

    ////////////////////////////////////////////////////////////////////
    // straps caught once after reset release
    reg       strap_done_reg;
    reg [1:0] wmode_reg;
    reg       pin_rst_en_reg;
    reg       bor_en_reg;
    reg       ost_en_reg;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_done_reg <= 1'b0;
            wmode_reg      <= `SWC_WM_OFF;
            pin_rst_en_reg <= 1'b0;
            bor_en_reg     <= 1'b0;
            ost_en_reg     <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            wmode_reg      <= wdt_mode_i;
            pin_rst_en_reg <= ext_reset_en_i;
            bor_en_reg     <= brownout_en_i;
            ost_en_reg     <= xtal_mode_i & ~two_speed_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] intctl_reg;
    reg [7:0] pflags_reg;
    reg [7:0] wdtctl_reg;
    reg [NPI-1:0] pirqen_reg;
    reg [1:0] state_reg;
    reg [CNT_W-1:0] ost_cnt_reg;
    reg pend_d_reg;

    function sel;
        input [`SWC_ADDR_W-1:0] a;
        input [`SWC_ADDR_W-1:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    wire wr_ic = wr_i & sel(addr_i, `SWC_OFF_INTCTL);
    wire wr_pf = wr_i & sel(addr_i, `SWC_OFF_PFLAGS);
    wire wr_wc = wr_i & sel(addr_i, `SWC_OFF_WDTCTL);
    wire wr_pe = wr_i & sel(addr_i, `SWC_OFF_PIRQEN);

    // individual enables gate wake; global enable is not consulted
    wire pending = (intctl_reg[`SWC_IC_TMR_EN] & intctl_reg[`SWC_IC_TMR_FLG])
                 | (intctl_reg[`SWC_IC_PIN_EN] & intctl_reg[`SWC_IC_PIN_FLG])
                 | (intctl_reg[`SWC_IC_CHG_EN] & intctl_reg[`SWC_IC_CHG_FLG])
                 | (intctl_reg[`SWC_IC_PER_EN] & (|(periph_irq_i & pirqen_reg)));

    wire asleep    = (state_reg == ST_SLEEP);
    // decision uses the pending state sampled before this cycle
    wire enter     = sleep_instr_i & (state_reg == ST_AWAKE) & ~pend_d_reg;
    wire rst_pin   = pin_rst_en_reg & pin_rst_s;
    wire rst_bor   = bor_en_reg & bor_s;
    wire ext_rst   = rst_pin | rst_bor;

    ////////////////////////////////////////////////////////////////////
    // watchdog
    wire wdt_exp;
    reg  wdt_active;
    always @* begin
        case (wmode_reg)
            `SWC_WM_ON:      wdt_active = 1'b1;
            `SWC_WM_NOSLEEP: wdt_active = ~asleep;
            `SWC_WM_SW:      wdt_active = wdtctl_reg[`SWC_WC_SWEN];
            default:         wdt_active = 1'b0;
        endcase
    end

    wire wake_evt  = asleep & (pending | wdt_exp);
    wire wdt_clear = enter | watchdog_kick_instr_i | wake_evt
                   | (state_reg == ST_OST) | ~strap_done_reg;

    swc_wdt #(
        .CW        (24)
    ) u_wdt (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .active_i  (wdt_active & strap_done_reg),
        .clear_i   (wdt_clear),
        .lf_tick_i (lf_tick),
        .ps_i      (wdtctl_reg[`SWC_WC_PS_HI:`SWC_WC_PS_LO]),
        .expire_o  (wdt_exp)
    );

    // expiry while awake is a device reset; asleep it only wakes
    wire wdt_rst = wdt_exp & ~asleep;

    ////////////////////////////////////////////////////////////////////
    // state machine
    reg [1:0] state_next;
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_AWAKE: begin
                if (enter) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (ext_rst) begin
                    state_next = ST_AWAKE;
                end else if (wake_evt) begin
                    state_next = ost_en_reg ? ST_OST : ST_AWAKE;
                end
            end
            ST_OST: begin
                if (ext_rst || ost_cnt_reg == OST_LAST) begin
                    state_next = ST_AWAKE;
                end
            end
            default: state_next = ST_AWAKE;
        endcase
    end

    wire resume_now = ((state_reg == ST_SLEEP) & wake_evt & ~ost_en_reg & ~ext_rst)
                    | ((state_reg == ST_OST) & (ost_cnt_reg == OST_LAST) & ~ext_rst);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg    <= ST_AWAKE;
            ost_cnt_reg  <= {CNT_W{1'b0}};
            pend_d_reg   <= 1'b0;
            lf_d_reg     <= 1'b0;
            extirq_d_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            pend_d_reg   <= pending;
            lf_d_reg     <= lf_s;
            extirq_d_reg <= extirq_s;
            if (state_reg == ST_OST) begin
                ost_cnt_reg <= ost_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                ost_cnt_reg <= {CNT_W{1'b0}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register updates; hardware set wins over software clear
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            intctl_reg <= `SWC_IC_RST;
            pflags_reg <= `SWC_PF_RST;
            wdtctl_reg <= `SWC_WC_RST;
            pirqen_reg <= {NPI{1'b0}};
        end else begin
            if (wr_ic) begin
                intctl_reg <= wdata_i;
            end
            if (tmr0_evt_i) begin
                intctl_reg[`SWC_IC_TMR_FLG] <= 1'b1;
            end
            if (ext_edge) begin
                intctl_reg[`SWC_IC_PIN_FLG] <= 1'b1;
            end
            if (ioc_evt_i) begin
                intctl_reg[`SWC_IC_CHG_FLG] <= 1'b1;
            end
            if (wr_pf) begin
                pflags_reg[2:0] <= wdata_i[2:0];
            end
            if (wr_wc) begin
                wdtctl_reg <= wdata_i & `SWC_WC_MASK;
            end
            if (wr_pe) begin
                pirqen_reg <= wdata_i[NPI-1:0];
            end
            // flag effects, latest event in the cycle last
            if (watchdog_kick_instr_i) begin
                pflags_reg[`SWC_PF_EXPIRED] <= 1'b1;
                pflags_reg[`SWC_PF_PDOWN]   <= 1'b1;
            end
            if (enter) begin
                pflags_reg[`SWC_PF_PDOWN]   <= 1'b0;
                pflags_reg[`SWC_PF_EXPIRED] <= 1'b1;
            end
            if (wdt_rst) begin
                pflags_reg[`SWC_PF_EXPIRED] <= 1'b0;
                pflags_reg[`SWC_PF_PDOWN]   <= 1'b1;
            end
            if (asleep && wdt_exp) begin
                pflags_reg[`SWC_PF_EXPIRED] <= 1'b0;
                pflags_reg[`SWC_PF_PDOWN]   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port, data in the cycle after the strobe
    reg [7:0] rmux;
    always @* begin
        case (addr_i)
            `SWC_OFF_INTCTL: rmux = intctl_reg;
            `SWC_OFF_PFLAGS: rmux = pflags_reg;
            `SWC_OFF_WDTCTL: rmux = wdtctl_reg;
            `SWC_OFF_PIRQEN: rmux = {{(8-NPI){1'b0}}, pirqen_reg};
            default:         rmux = 8'h00;
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rmux;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cpu_clk_en_o                <= 1'b1;
            lf_clk_en_o                 <= 1'b1;
            timer_osc_en_o              <= 1'b1;
            adc_dedicated_rc_clock_en_o <= 1'b1;
            cap_osc_en_o                <= 1'b1;
            io_hold_o                   <= 1'b0;
            sys_reset_o                 <= 1'b0;
            resume_o                    <= 1'b0;
            isr_call_o                  <= 1'b0;
            isr_vector_o                <= `SWC_ISR_VECTOR;
            prefetch_addr_o             <= {`SWC_PC_W{1'b0}};
            prefetch_o                  <= 1'b0;
            asleep_o                    <= 1'b0;
        end else begin
            // slow clocks are never gated by sleep
            lf_clk_en_o                 <= 1'b1;
            timer_osc_en_o              <= 1'b1;
            adc_dedicated_rc_clock_en_o <= 1'b1;
            cap_osc_en_o                <= 1'b1;
            cpu_clk_en_o                <= (state_next == ST_AWAKE);
            io_hold_o                   <= (state_next != ST_AWAKE);
            asleep_o                    <= (state_next != ST_AWAKE);
            sys_reset_o                 <= ext_rst | wdt_rst;
            resume_o                    <= resume_now;
            // a watchdog wake with no interrupt pending resumes in line
            isr_call_o                  <= resume_now & pending & intctl_reg[`SWC_IC_GLB_EN];
            isr_vector_o                <= `SWC_ISR_VECTOR;
            prefetch_o                  <= sleep_instr_i;
            if (sleep_instr_i) begin
                prefetch_addr_o <= pc_i + {{(`SWC_PC_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// [design/swc_wdt.v]
// Purpose: watchdog counter on low-frequency ticks
// Assumes: lf_tick_i is a one-cycle pulse per oscillator period
// Notes:   clear_i has priority over counting
`timescale 1ns/1ps
`include "swc_regs.vh"
module swc_wdt #(
    parameter CW = 24
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         nrst_i,
    // control
    input  wire         active_i,
    input  wire         clear_i,
    input  wire         lf_tick_i,
    input  wire [4:0]   ps_i,
    // status
    output reg          expire_o
);
    reg  [CW-1:0] cnt_reg;
    wire [4:0]    ps_eff;
    wire [CW-1:0] limit;

    // reserved selections fall back to the shortest interval
    assign ps_eff = (ps_i > `SWC_PS_MAX) ? 5'h00 : ps_i;
    assign limit  = ({{(CW-1){1'b0}}, 1'b1} << (ps_eff + `SWC_PS_BASE_LOG2)) - {{(CW-1){1'b0}}, 1'b1};

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg  <= {CW{1'b0}};
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (clear_i || !active_i) begin
                cnt_reg <= {CW{1'b0}};
            end else if (lf_tick_i) begin
                if (cnt_reg >= limit) begin
                    cnt_reg  <= {CW{1'b0}};
                    expire_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// [dv/swc_cpu_model.sv]
// Purpose: cpu core stand-in issuing sleep and watchdog-clear instructions
// Assumes: each strobe is one execute cycle on clk_i
// Notes:   a gated core executes nothing, so issue waits for the clock enable
`timescale 1ns/1ps
`include "swc_regs.vh"
module swc_cpu_model (
    // clock
    input  wire                 clk_i,
    input  wire                 cpu_clk_en_i,
    // instruction strobes
    output reg                  sleep_o,
    output reg                  kick_o,
    output reg [`SWC_PC_W-1:0]  pc_o
);
    initial begin
        sleep_o = 1'b0;
        kick_o = 1'b0;
        pc_o = 13'h0000;
    end
    task issue(input bit slp, input [`SWC_PC_W-1:0] pc);
        @(posedge clk_i);
        while (cpu_clk_en_i !== 1'b1) @(posedge clk_i);
        sleep_o <= slp;
        kick_o <= ~slp;
        pc_o <= pc;
        @(posedge clk_i);
        sleep_o <= 1'b0;
        kick_o <= 1'b0;
    endtask
endmodule

// [dv/swc_props_properties.sv]
// Purpose: port-level properties of the sleep/wake controller
// Assumes: bound to every instance of swc_top
// Notes:   reset-request checks allow eight cycles for the pin filter
`timescale 1ns/1ps
`include "swc_regs.vh"
module swc_props #(
    parameter NPI        = 8,
    parameter OST_CYCLES = 1024
) (
    // clock and reset
    input wire                 clk_i,
    input wire                 nrst_i,
    // watched inputs
    input wire                 sleep_instr_i,
    input wire [`SWC_PC_W-1:0] pc_i,
    input wire                 external_reset_pin_n_i,
    input wire                 ext_reset_en_i,
    input wire                 brownout_i,
    input wire                 brownout_en_i,
    // watched outputs
    input wire                 cpu_clk_en_o,
    input wire                 lf_clk_en_o,
    input wire                 timer_osc_en_o,
    input wire                 adc_dedicated_rc_clock_en_o,
    input wire                 cap_osc_en_o,
    input wire                 io_hold_o,
    input wire                 sys_reset_o,
    input wire                 resume_o,
    input wire                 isr_call_o,
    input wire [`SWC_PC_W-1:0] isr_vector_o,
    input wire [`SWC_PC_W-1:0] prefetch_addr_o,
    input wire                 prefetch_o,
    input wire                 asleep_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////
    property p_entry; $rose(asleep_o) |-> $past(sleep_instr_i); endproperty
    a_entry: assert property (p_entry) else $error("sleep without instruction");
    property p_gated; asleep_o |-> !cpu_clk_en_o && io_hold_o; endproperty
    a_gated: assert property (p_gated) else $error("cpu clock or pins not held");
    property p_osc; lf_clk_en_o && timer_osc_en_o && adc_dedicated_rc_clock_en_o && cap_osc_en_o; endproperty
    a_osc: assert property (p_osc) else $error("slow clock stopped");
    // pc + 1 must wrap inside the address width
    property p_pref; $rose(asleep_o) |-> prefetch_o && prefetch_addr_o == $past(pc_i) + 1'b1; endproperty
    a_pref: assert property (p_pref) else $error("prefetch wrong");
    property p_res; resume_o |-> $past(asleep_o) && !asleep_o && cpu_clk_en_o && !io_hold_o && !sys_reset_o;
    endproperty
    a_res: assert property (p_res) else $error("resume state wrong");
    property p_pulse; resume_o |=> !resume_o; endproperty
    a_pulse: assert property (p_pulse) else $error("resume not a pulse");
    property p_isr; isr_call_o |-> resume_o && isr_vector_o == 13'h0004; endproperty
    a_isr: assert property (p_isr) else $error("isr call wrong");
    property p_pin; (ext_reset_en_i && !external_reset_pin_n_i) [*8] |-> sys_reset_o; endproperty
    a_pin: assert property (p_pin) else $error("pin reset missed");
    property p_bor; (brownout_en_i && brownout_i) [*8] |-> sys_reset_o; endproperty
    a_bor: assert property (p_bor) else $error("brownout reset missed");
endmodule

bind swc_top swc_props #(.NPI(NPI), .OST_CYCLES(OST_CYCLES)) u_props (.*);

// [dv/tb_sleep_wake_controller.sv]
// Purpose: self-checking bench of the sleep/wake controller
// Assumes: start-up wait shortened to OSCILLATOR_STARTUP_TIMER cycles
// Notes:   slow oscillator sped up to 46 ns so watchdog periods fit the run
`timescale 1ns/1ps
`include "swc_regs.vh"
module tb_sleep_wake_controller;
    localparam OSCILLATOR_STARTUP_TIMER = 8;
    reg          clk_i, nrst_i, wr_i, rd_i, tmr0_evt_i, ioc_evt_i, ext_irq_pin_i;
    reg          external_reset_pin_n_i, brownout_i, low_freq_internal_osc_i;
    reg          ext_reset_en_i, brownout_en_i, xtal_mode_i, two_speed_i;
    reg  [2:0]   addr_i;
    reg  [7:0]   wdata_i, periph_irq_i;
    reg  [1:0]   wdt_mode_i;
    wire         sleep_instr_i, watchdog_kick_instr_i, cpu_clk_en_o, lf_clk_en_o, timer_osc_en_o;
    wire         adc_dedicated_rc_clock_en_o, cap_osc_en_o, io_hold_o, sys_reset_o;
    wire         resume_o, isr_call_o, prefetch_o, asleep_o;
    wire [12:0]  pc_i, isr_vector_o, prefetch_addr_o;
    wire [7:0]   rdata_o;
    integer      err_total, cmp_count, cyc, n0, n;

    swc_top #(.OST_CYCLES(OSCILLATOR_STARTUP_TIMER)) DUT (.*);
    swc_cpu_model cpu (.clk_i(clk_i), .cpu_clk_en_i(cpu_clk_en_o), .sleep_o(sleep_instr_i),
        .kick_o(watchdog_kick_instr_i), .pc_o(pc_i));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        low_freq_internal_osc_i = 1'b0;
        forever #23 low_freq_internal_osc_i = ~low_freq_internal_osc_i;
    end
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////////
    task final_report;
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp, input [8*8:1] w);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: %0s got %h exp %h", $time, w, got, exp);
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input [2:0] a, input [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e, "rdata");
    endtask
    // sel 1 waits for sys_reset_o, 0 for resume_o; n returns edges taken
    task waitfor(input bit sel, input integer lim);
        n = 0;
        while ((sel ? sys_reset_o : resume_o) !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            #1 n = n + 1;
        end
    endtask
    task tick0;
        @(posedge clk_i);
        tmr0_evt_i <= 1'b1;
        @(posedge clk_i);
        tmr0_evt_i <= 1'b0;
    endtask
    task go_sleep;
        cpu.issue(1'b1, 13'h1fff);
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task do_reset(input bit x, input [1:0] m);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        xtal_mode_i <= x;
        wdt_mode_i <= m;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    task t_regs;
        rd(`SWC_OFF_INTCTL, `SWC_IC_RST);
        rd(`SWC_OFF_PFLAGS, `SWC_PF_RST);
        rd(`SWC_OFF_WDTCTL, `SWC_WC_RST);
        rd(`SWC_OFF_PIRQEN, `SWC_PIRQEN_RST);
        wr(`SWC_OFF_WDTCTL, 8'hff);
        rd(`SWC_OFF_WDTCTL, 8'h3f);
        wr(`SWC_OFF_PFLAGS, 8'hff);
        rd(`SWC_OFF_PFLAGS, 8'h1f);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        wr(`SWC_OFF_PFLAGS, 8'h00);
        wr(`SWC_OFF_WDTCTL, `SWC_WC_RST);
    endtask
    task t_int(input bit g);
        wr(`SWC_OFF_INTCTL, {g, 7'h20});
        go_sleep;
        chk({asleep_o, cpu_clk_en_o, io_hold_o}, 3'b101, "entry");
        rd(`SWC_OFF_PFLAGS, 8'h10);
        tick0;
        waitfor(0, 2000);
        chk({resume_o, isr_call_o, isr_vector_o}, {1'b1, g, 13'h0004}, "wake");
        wr(`SWC_OFF_INTCTL, 8'h00);
    endtask
    task t_nop;
        cpu.issue(1'b0, 13'h0000);
        wr(`SWC_OFF_INTCTL, 8'h20);
        tick0;
        @(posedge clk_i);
        go_sleep;
        chk(asleep_o, 1'b0, "nop");
        rd(`SWC_OFF_PFLAGS, 8'h18);
        wr(`SWC_OFF_INTCTL, 8'h00);
    endtask
    task t_mask;
        go_sleep;
        tick0;
        repeat (20) @(posedge clk_i);
        #1 chk(asleep_o, 1'b1, "masked");
        @(posedge clk_i);
        periph_irq_i <= 8'h80;
        wr(`SWC_OFF_PIRQEN, 8'h80);
        wr(`SWC_OFF_INTCTL, 8'h40);
        waitfor(0, 50);
        chk({resume_o, isr_call_o}, 2'b10, "periph");
        @(posedge clk_i);
        periph_irq_i <= 8'h00;
        wr(`SWC_OFF_PIRQEN, 8'h00);
        wr(`SWC_OFF_INTCTL, 8'h00);
    endtask
    task t_off;
        go_sleep;
        repeat (400) @(posedge clk_i);
        #1 chk(asleep_o, 1'b1, "wdt off");
        @(posedge clk_i);
        external_reset_pin_n_i <= 1'b0;
        waitfor(1, 20);
        chk({sys_reset_o, resume_o}, 2'b10, "pin rst");
        repeat (3) @(posedge clk_i);
        #1 chk(asleep_o, 1'b0, "pin wake");
        @(posedge clk_i);
        external_reset_pin_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        go_sleep;
        @(posedge clk_i);
        brownout_i <= 1'b1;
        waitfor(1, 20);
        chk({sys_reset_o, resume_o, asleep_o}, 3'b100, "bor");
        repeat (4) @(posedge clk_i);
        brownout_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    task t_wdt;
        wr(`SWC_OFF_WDTCTL, 8'h00);
        go_sleep;
        waitfor(0, 2000);
        chk({resume_o, isr_call_o}, 2'b10, "wdt wake");
        rd(`SWC_OFF_PFLAGS, 8'h00);
        waitfor(1, 2000);
        chk(sys_reset_o, 1'b1, "wdt rst");
        chk(n > 270 && n < 320, 1'b1, "period");
        rd(`SWC_OFF_PFLAGS, 8'h08);
    endtask
    // shortest period would expire well inside 400 cycles if still counting
    task t_mode;
        do_reset(1'b0, `SWC_WM_NOSLEEP);
        wr(`SWC_OFF_WDTCTL, 8'h00);
        go_sleep;
        repeat (400) @(posedge clk_i);
        #1 chk(asleep_o, 1'b1, "nosleep");
        do_reset(1'b0, `SWC_WM_SW);
        wr(`SWC_OFF_WDTCTL, 8'h01);
        waitfor(1, 400);
        chk(sys_reset_o, 1'b1, "sw mode");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {nrst_i, wr_i, rd_i, tmr0_evt_i, ioc_evt_i, ext_irq_pin_i, brownout_i} = 7'h00;
        {external_reset_pin_n_i, ext_reset_en_i, brownout_en_i} = 3'h7;
        {xtal_mode_i, two_speed_i, wdt_mode_i} = 4'h0;
        {addr_i, wdata_i, periph_irq_i} = 19'h00000;
        {err_total, cmp_count, cyc, n0, n} = {5{32'h0}};
        do_reset(1'b0, `SWC_WM_OFF);
        t_regs;
        t_int(1'b0);
        n0 = n;
        t_int(1'b1);
        t_nop;
        t_mask;
        t_off;
        t_mode;
        do_reset(1'b1, `SWC_WM_ON);
        t_int(1'b1);
        chk(n, n0 + OSCILLATOR_STARTUP_TIMER, "ost");
        t_wdt;
        final_report;
    end
endmodule
